/* src/voice_store_pkg.sv */
package voice_store_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	// message end pulse length in microseconds
	localparam int unsigned MESSAGE_END_PULSE_TIME_US = 12;
	localparam int unsigned MESSAGE_END_PULSE_CYC_RAW = MESSAGE_END_PULSE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned MESSAGE_END_PULSE_CYC = (MESSAGE_END_PULSE_CYC_RAW < 1) ? 1 :
		MESSAGE_END_PULSE_CYC_RAW;
	// overflow pulse length in clock cycles
	localparam int unsigned FULL_PULSE_CYC = 4;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned ADDR_W = 10;
	localparam logic [ADDR_W-1:0] ARRAY_LAST = 10'h3FF;
	localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FULL_PULSE, ST_FULL_FOLLOW} op_state_e;
endpackage : voice_store_pkg

/* src/pulse_timer.sv */
`timescale 1ns/1ps
module pulse_timer
	import voice_store_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [CNT_W-1:0] length,
	output logic busy
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} timer_s;
	timer_s cur_ff;
	timer_s nxt_ff;
	always_comb begin
		nxt_ff = cur_ff;
		if (start) begin
			nxt_ff.cnt = length;
		end else if (cur_ff.cnt != '0) begin
			nxt_ff.cnt = CNT_W'(cur_ff.cnt - 1'b1);
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end
	assign busy = (cur_ff.cnt != '0);
endmodule : pulse_timer

/* src/voice_store_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - reaching the end of the array during record or playback pulses array_full_flag low.
// - after that pulse array_full_flag follows chip enable until standby_request resets it.
// - address and playback/record select are captured on the falling edge of chip enable.
// - standby_request after an overflow returns the address pointer to the array start.
// - each recorded message gets an end marker; only the latest is kept, and recording over it clears it.
// - message_end_flag pulses low for the message end pulse time plus one clock cycle at each message end, except one cut by the array end.
// - a low supply holds message_end_flag low and locks the device to playback only.
// - in push_button_mode message_end_flag is high while recording or playing.
// - in push_button_mode a chip enable fall also stops the operation; standby_request stops it in either mode.
module voice_store_ctrl
	import voice_store_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic chip_enable_n,
	input wire logic standby_request,
	input wire logic play_not_record,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic push_button_mode,
	input wire logic supply_low,
	input wire logic sample_tick,
	output logic array_full_flag_n,
	output logic message_end_flag,
	output logic recording,
	output logic playing,
	output logic [ADDR_W-1:0] mem_addr,
	output logic marker_write,
	output logic standby
);
	typedef struct packed {
		op_state_e st;
		logic ce_n_d;
		logic play;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] marker_addr;
		logic marker_valid;
		logic full_n;
		logic eom_out;
		logic mwr;
		logic [CNT_W-1:0] full_cnt;
	} ctrl_s;
	// reset image: both status outputs idle high, pointer at the array start
	localparam ctrl_s CTRL_RST = '{
		st: ST_IDLE,
		ce_n_d: 1'b1,
		play: 1'b1,
		addr: ADDR_RST,
		marker_addr: ADDR_RST,
		marker_valid: 1'b0,
		full_n: 1'b1,
		eom_out: 1'b1,
		mwr: 1'b0,
		full_cnt: '0
	};

	function automatic logic is_running(input op_state_e st);
		return (st == ST_RUN);
	endfunction : is_running

	function automatic logic at_array_end(input logic [ADDR_W-1:0] a);
		return (a == ARRAY_LAST);
	endfunction : at_array_end

	// the pointer never wraps by itself: the array end is caught before the step
	function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a);
		return ADDR_W'(a + 1'b1);
	endfunction : step_addr

	// in push-button mode a second chip enable fall ends the operation
	function automatic logic stop_request(input logic sby, input logic pb, input logic fall);
		return sby || (pb && fall);
	endfunction : stop_request

	// one compare serves both the playback stop and the retiring of an old marker
	function automatic logic on_marker(input ctrl_s s);
		return s.marker_valid && (s.addr == s.marker_addr);
	endfunction : on_marker

	// only one marker is kept, so a new message end replaces the old one
	function automatic ctrl_s mark_end(input ctrl_s s);
		mark_end = s;
		mark_end.marker_addr = s.addr;
		mark_end.marker_valid = 1'b1;
		mark_end.mwr = 1'b1;
	endfunction : mark_end
	ctrl_s cur_ff;
	ctrl_s nxt_ff;
	logic eom_start;
	logic eom_busy;
	logic ce_fall;
	logic at_marker;

	pulse_timer u_eom_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(eom_start),
		.length(CNT_W'(MESSAGE_END_PULSE_CYC)),
		.busy(eom_busy)
	);

	assign ce_fall = cur_ff.ce_n_d && !chip_enable_n;
	assign at_marker = on_marker(cur_ff);

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.ce_n_d = chip_enable_n;
		nxt_ff.mwr = 1'b0;
		eom_start = 1'b0;

		unique case (cur_ff.st)
			// a fall while standby is held is refused: the part sleeps
			ST_IDLE: begin
				if (ce_fall && !standby_request) begin
					nxt_ff.play = play_not_record || supply_low;
					nxt_ff.addr = addr_in;
					nxt_ff.st = ST_RUN;
				end
			end

			// a stop outranks a tick in the same cycle
			ST_RUN: begin
				// stop by standby in any mode, or by chip enable in push-button mode
				if (stop_request(standby_request, push_button_mode, ce_fall)) begin
					if (!cur_ff.play) begin
						nxt_ff = mark_end(nxt_ff);
					end
					eom_start = 1'b1;
					nxt_ff.st = ST_IDLE;
				end else if (sample_tick) begin
					if (cur_ff.play && at_marker) begin
						eom_start = 1'b1;
						nxt_ff.st = ST_IDLE;
					end else if (at_array_end(cur_ff.addr)) begin
						nxt_ff.full_n = 1'b0;
						nxt_ff.full_cnt = CNT_W'(FULL_PULSE_CYC);
						// a recording cut by the array end still gets its marker
						if (!cur_ff.play) begin
							nxt_ff = mark_end(nxt_ff);
						end
						nxt_ff.st = ST_FULL_PULSE;
					end else begin
						if (!cur_ff.play && at_marker) begin
							nxt_ff.marker_valid = 1'b0;
						end
						nxt_ff.addr = step_addr(cur_ff.addr);
					end
				end
			end

			// chip enable is not followed until the pulse has run out
			ST_FULL_PULSE: begin
				if (cur_ff.full_cnt > CNT_W'(1)) begin
					nxt_ff.full_cnt = CNT_W'(cur_ff.full_cnt - 1'b1);
				end else begin
					nxt_ff.full_cnt = '0;
					nxt_ff.st = ST_FULL_FOLLOW;
				end
			end

			// a new operation waits here until standby_request
			ST_FULL_FOLLOW: begin
				if (standby_request) begin
					nxt_ff.addr = ADDR_RST;
					nxt_ff.st = ST_IDLE;
				end
			end
		endcase

		if (nxt_ff.st == ST_FULL_FOLLOW) begin
			nxt_ff.full_n = chip_enable_n;
		end else if (nxt_ff.st != ST_FULL_PULSE) begin
			nxt_ff.full_n = 1'b1;
		end

		// the low-supply hold outranks the pulse and the busy indicator
		// supply low holds flag low
		if (supply_low) begin
			nxt_ff.eom_out = 1'b0;
		end else if (push_button_mode) begin
			nxt_ff.eom_out = is_running(nxt_ff.st);
		end else begin
			nxt_ff.eom_out = !(eom_start || eom_busy);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff <= CTRL_RST;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// the overflow output doubles as the next device's chip enable in a chain
	assign array_full_flag_n = cur_ff.full_n;
	assign message_end_flag = cur_ff.eom_out;
	assign recording = is_running(cur_ff.st) && !cur_ff.play;
	assign playing = is_running(cur_ff.st) && cur_ff.play;
	assign mem_addr = cur_ff.addr;
	assign marker_write = cur_ff.mwr;
	assign standby = standby_request && (cur_ff.st == ST_IDLE);
endmodule : voice_store_ctrl

/* tb/voice_store_assertions.sv */
`timescale 1ns/1ps
module voice_store_assertions
	import voice_store_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic chip_enable_n,
	input wire logic standby_request,
	input wire logic play_not_record,
	input wire logic supply_low,
	input wire logic push_button_mode,
	input wire logic sample_tick,
	input wire logic array_full_flag_n,
	input wire logic message_end_flag,
	input wire logic recording,
	input wire logic playing,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic marker_write
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_full;
		(recording | playing) && sample_tick && mem_addr == ARRAY_LAST |=> !array_full_flag_n [*4];
	endproperty
	a_full: assert property (p_full) else $error("overflow pulse short");
	property p_follow;
		$fell(array_full_flag_n) |-> ##4 array_full_flag_n == $past(chip_enable_n);
	endproperty
	a_follow: assert property (p_follow) else $error("overflow not following");
	// a refused start would leave both low
	property p_start;
		$fell(chip_enable_n) && !standby_request && !recording && !playing && !push_button_mode
			&& mem_addr != ARRAY_LAST
			|=> (recording ^ playing) && playing == ($past(play_not_record) | $past(supply_low));
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_end;
		$fell(message_end_flag) && !supply_low && !push_button_mode |-> !message_end_flag [*8];
	endproperty
	a_end: assert property (p_end) else $error("end pulse short");
	property p_low;
		(supply_low && !push_button_mode) [*2] |-> !message_end_flag;
	endproperty
	a_low: assert property (p_low) else $error("low supply flag high");
	property p_lock;
		supply_low && $past(supply_low) |-> !$rose(recording);
	endproperty
	a_lock: assert property (p_lock) else $error("record on low supply");
	property p_push;
		(push_button_mode && playing) [*2] |-> message_end_flag;
	endproperty
	a_push: assert property (p_push) else $error("busy flag low");
	property p_mark;
		marker_write |-> $past(recording) || $past(recording, 2);
	endproperty
	a_mark: assert property (p_mark) else $error("stray marker");
endmodule : voice_store_assertions
bind voice_store_ctrl voice_store_assertions u_voice_store_assertions (.*);

/* tb/ctrl_model.sv */
`timescale 1ns/1ps
module ctrl_model
	import voice_store_pkg::*;
(
	input wire logic clk_sys,
	output logic chip_enable_n = 1'h1,
	output logic standby_request = 1'h0,
	output logic play_not_record = 1'h1,
	output logic [ADDR_W-1:0] addr_in = 10'h000,
	output logic sample_tick = 1'h0
);
	task automatic start(input logic play, input logic [ADDR_W-1:0] addr);
		@(negedge clk_sys) {chip_enable_n, play_not_record, addr_in} = {1'h1, play, addr};
		@(negedge clk_sys) chip_enable_n = 1'h0;
		// address released after capture, so it changes
		@(negedge clk_sys) addr_in = ~addr;
	endtask : start
	task automatic tick();
		@(negedge clk_sys) sample_tick = 1'h1;
		@(negedge clk_sys) sample_tick = 1'h0;
	endtask : tick
	task automatic lift();
		@(negedge clk_sys) chip_enable_n = 1'h1;
	endtask : lift
	task automatic hold();
		@(negedge clk_sys) chip_enable_n = 1'h0;
	endtask : hold
	task automatic rest();
		@(negedge clk_sys) {chip_enable_n, standby_request} = 2'h3;
		@(negedge clk_sys) standby_request = 1'h0;
	endtask : rest
endmodule : ctrl_model

/* tb/voice_store_ctrl_tb.sv */
`timescale 1ns/1ps
module voice_store_ctrl_tb;
	import voice_store_pkg::*;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic push_button_mode = 1'h0;
	logic supply_low = 1'h0;
	logic chip_enable_n, standby_request, play_not_record, sample_tick;
	logic [ADDR_W-1:0] addr_in, mem_addr;
	logic array_full_flag_n, message_end_flag, recording, playing, marker_write, standby;
	int error_cnt = 0;
	int n_tests = 0;
	int full_lo, end_lo, marks, sby;
	always #20 clk_sys = ~clk_sys;
	// pulse widths counted per cycle rather than guessed from edges
	always @(posedge clk_sys) begin
		full_lo <= full_lo + int'(!array_full_flag_n);
		end_lo <= end_lo + int'(!message_end_flag);
		marks <= marks + int'(marker_write);
		sby <= sby + int'(standby);
	end
	ctrl_model u_ctrl_model (.*);
	voice_store_ctrl u_voice_store_ctrl (.*);
	task automatic check(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %b got %b", what, exp, got);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	task automatic overflow_case();
		u_ctrl_model.start(1'h1, 10'h3FE);
		@(negedge clk_sys) full_lo = 0;
		check("playing", 1'h1, playing);
		check("start addr", 1'h1, mem_addr === 10'h3FE);
		u_ctrl_model.tick();
		u_ctrl_model.tick();
		u_ctrl_model.lift();
		repeat (10) @(negedge clk_sys);
		check("overflow width", 1'h1, full_lo == FULL_PULSE_CYC);
		u_ctrl_model.hold();
		@(negedge clk_sys);
		check("overflow follows", 1'h0, array_full_flag_n);
		u_ctrl_model.rest();
		@(negedge clk_sys);
		check("pointer home", 1'h1, mem_addr === ADDR_RST);
	endtask : overflow_case
	task automatic record_case();
		u_ctrl_model.start(1'h0, 10'h010);
		@(negedge clk_sys) {end_lo, marks} = 0;
		check("recording", 1'h1, recording);
		u_ctrl_model.rest();
		repeat (400) @(negedge clk_sys);
		check("end width", 1'h1, end_lo == MESSAGE_END_PULSE_CYC + 1);
		check("one marker", 1'h1, marks == 1);
	endtask : record_case
	task automatic supply_case();
		supply_low = 1'h1;
		repeat (2) @(negedge clk_sys);
		check("low supply flag", 1'h0, message_end_flag);
		u_ctrl_model.start(1'h0, 10'h020);
		@(negedge clk_sys);
		check("forced play", 1'h1, playing);
		u_ctrl_model.rest();
		supply_low = 1'h0;
		repeat (400) @(negedge clk_sys);
		check("flag idle", 1'h1, message_end_flag);
	endtask : supply_case
	task automatic push_case();
		push_button_mode = 1'h1;
		u_ctrl_model.start(1'h1, 10'h030);
		@(negedge clk_sys);
		check("busy flag", 1'h1, message_end_flag & playing);
		u_ctrl_model.start(1'h1, 10'h030);
		@(negedge clk_sys);
		check("fall stops", 1'h0, playing);
		push_button_mode = 1'h0;
		sby = 0;
		u_ctrl_model.rest();
		@(negedge clk_sys);
		check("standby", 1'h1, sby == 1);
	endtask : push_case
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'h1;
		overflow_case();
		record_case();
		supply_case();
		push_case();
		summarize();
	end
endmodule : voice_store_ctrl_tb
